// [verilog/quad_encoder_rate_mult.sv]
module quad_encoder_rate_mult
    import qenc_pkg::*;
#(
    parameter int unsigned RM_PERIOD_MAX = RM_PERIOD_MAX_CYC,
    parameter logic [15:0] MUL_MIN = FACTOR_MIN_DEF,
    parameter logic [15:0] MUL_MAX = FACTOR_MAX_DEF,
    parameter logic [15:0] DIV_MIN = FACTOR_MIN_DEF,
    parameter logic [15:0] DIV_MAX = FACTOR_MAX_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire apb_req_s apb_req_in,
    output apb_rsp_s apb_rsp_out,
    input wire logic [NUM_PORTS-1:0] port_in,
    output logic tick_out,
    output logic [31:0] position_count_out,
    output logic target_clear_out,
    output logic rate_pulse_out,
    output logic frame_start_enable_out,
    output logic [3:0] trig_event_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] phase_input_select;
        logic [1:0] quadrature_input_select;
        logic bidirectional_tick_enable;
        logic [1:0] external_clear_port_select;
        logic external_clear_edge_mode;
        logic external_clear_polarity_invert;
        clear_source_e position_clear_source;
        logic [15:0] hyst;
        logic [FACTOR_W-1:0] mul;
        logic [FACTOR_W-1:0] div;
        logic rm_src_tick;
        logic [1:0] rm_port;
        logic fs_from_rm;
        logic fs_enable;
        logic [1:0] route_port;
        logic [3:0] route_en;
        logic [31:0] position_count;
        logic [31:0] mark;
        logic forward;
        logic tick;
        logic clr_prev;
        logic clr_pulse;
        logic [3:0] events;
        logic [31:0] rdata;
        logic slverr;
    } top_s;
    top_s q, d;

    step_s step;
    logic rm_pulse;
    logic rm_source;
    logic clr_level;
    logic ext_clear;
    logic sw_clear;
    logic do_clear;
    logic wr_en;
    logic setup;
    logic route_level;
    logic [31:0] pos_next;
    logic signed [31:0] delta;
    logic [31:0] rd_mux;
    logic rd_err;
    logic cfg_wr;
    logic clr_level_next;

    function automatic logic pick(input logic [NUM_PORTS-1:0] ports, input logic [1:0] sel);
        logic v;
        v = 1'b0;
        if (32'(sel) < NUM_PORTS) begin
            v = ports[sel];
        end
        return v;
    endfunction

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // ----------------------------------------
    // quadrature decoding
    // ----------------------------------------
    quad_step_decoder u_decoder (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .phase_in(pick(port_in, q.phase_input_select)),
        .quad_in(pick(port_in, q.quadrature_input_select)),
        .step_out(step)
    );

    // ----------------------------------------
    // rate multiplier
    // ----------------------------------------
    assign rm_source = q.rm_src_tick ? q.tick : pick(port_in, q.rm_port);

    rate_multiplier #(
        .PERIOD_MAX(RM_PERIOD_MAX)
    ) u_rate_mult (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .source_in(rm_source),
        .mul_in(q.mul),
        .div_in(q.div),
        .pulse_out(rm_pulse)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign setup = apb_req_in.psel & ~apb_req_in.penable;
    assign wr_en = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite;

    always_comb begin
        rd_mux = '0;
        rd_err = 1'b0;
        case (apb_req_in.paddr)
            REG_CONFIG: begin
                rd_mux[CFG_PHASE_LSB +: 2] = q.phase_input_select;
                rd_mux[CFG_QUAD_LSB +: 2] = q.quadrature_input_select;
                rd_mux[CFG_BIDIR_BIT] = q.bidirectional_tick_enable;
                rd_mux[CFG_XCLR_PORT_LSB +: 2] = q.external_clear_port_select;
                rd_mux[CFG_XCLR_EDGE_BIT] = q.external_clear_edge_mode;
                rd_mux[CFG_XCLR_INV_BIT] = q.external_clear_polarity_invert;
                rd_mux[CFG_CLR_SRC_BIT] = q.position_clear_source;
            end
            REG_POSITION: begin
                rd_mux = q.position_count;
            end
            REG_CLEAR: begin
                rd_mux = '0;
            end
            REG_HYST: begin
                rd_mux[15:0] = q.hyst;
            end
            REG_MUL: begin
                rd_mux[FACTOR_W-1:0] = q.mul;
            end
            REG_DIV: begin
                rd_mux[FACTOR_W-1:0] = q.div;
            end
            REG_RM_SRC: begin
                rd_mux[RMSRC_TICK_BIT] = q.rm_src_tick;
                rd_mux[RMSRC_PORT_LSB +: 2] = q.rm_port;
            end
            REG_MUL_BOUNDS: begin
                rd_mux = {MUL_MAX, MUL_MIN};
            end
            REG_DIV_BOUNDS: begin
                rd_mux = {DIV_MAX, DIV_MIN};
            end
            REG_TRIG: begin
                rd_mux[TRIG_FS_RM_BIT] = q.fs_from_rm;
                rd_mux[TRIG_FS_EN_BIT] = q.fs_enable;
                rd_mux[TRIG_ROUTE_PORT_LSB +: 2] = q.route_port;
                rd_mux[TRIG_ROUTE_EN_LSB +: 4] = q.route_en;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // position clear sources
    // ----------------------------------------
    assign clr_level = pick(port_in, q.external_clear_port_select) ^ q.external_clear_polarity_invert;
    assign cfg_wr = wr_en && (apb_req_in.paddr == REG_CONFIG);
    assign clr_level_next = cfg_wr ? (pick(port_in, apb_req_in.pwdata[CFG_XCLR_PORT_LSB +: 2]) ^
                                      apb_req_in.pwdata[CFG_XCLR_INV_BIT]) : clr_level;
    assign ext_clear = (q.position_clear_source == CLR_EXTERNAL) &&
                       (q.external_clear_edge_mode ? (clr_level & ~q.clr_prev) : clr_level);
    assign sw_clear = wr_en && (apb_req_in.paddr == REG_CLEAR) && apb_req_in.pwdata[CLR_SW_BIT] &&
                      (q.position_clear_source == CLR_SOFTWARE);
    assign do_clear = sw_clear | ext_clear;
    assign route_level = pick(port_in, q.route_port);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.clr_prev = clr_level_next;
        d.tick = 1'b0;
        d.clr_pulse = 1'b0;
        pos_next = step.up ? q.position_count + 32'h0000_0001 : q.position_count - 32'h0000_0001;
        delta = q.forward ? $signed(pos_next - q.mark) : $signed(q.mark - pos_next);

        if (!q.bidirectional_tick_enable) begin
            d.forward = 1'b1;
        end

        // position and tick generation
        if (do_clear) begin
            d.position_count = '0;
            d.mark = '0;
            d.forward = 1'b1;
            d.clr_pulse = 1'b1;
        end else if (step.valid) begin
            d.position_count = pos_next;
            if (delta > 0) begin
                d.tick = 1'b1;
                d.mark = pos_next;
            end else if (q.bidirectional_tick_enable && (-delta >= $signed({16'h0000, q.hyst}))) begin
                d.tick = 1'b1;
                d.mark = pos_next;
                d.forward = ~q.forward;
            end else begin
                d.mark = q.mark;
            end
        end

        // trigger routing
        d.events = q.route_en & {4{route_level}};
        if (q.fs_from_rm) begin
            d.events[EV_FRAME_START] = q.fs_enable & rm_pulse;
        end

        // register writes
        if (wr_en) begin
            case (apb_req_in.paddr)
                REG_CONFIG: begin
                    d.phase_input_select = apb_req_in.pwdata[CFG_PHASE_LSB +: 2];
                    d.quadrature_input_select = apb_req_in.pwdata[CFG_QUAD_LSB +: 2];
                    d.bidirectional_tick_enable = apb_req_in.pwdata[CFG_BIDIR_BIT];
                    d.external_clear_port_select = apb_req_in.pwdata[CFG_XCLR_PORT_LSB +: 2];
                    d.external_clear_edge_mode = apb_req_in.pwdata[CFG_XCLR_EDGE_BIT];
                    d.external_clear_polarity_invert = apb_req_in.pwdata[CFG_XCLR_INV_BIT];
                    d.position_clear_source = clear_source_e'(apb_req_in.pwdata[CFG_CLR_SRC_BIT]);
                end
                REG_HYST: begin
                    d.hyst = apb_req_in.pwdata[15:0];
                end
                REG_MUL: begin
                    d.mul = clamp(apb_req_in.pwdata[15:0], MUL_MIN, MUL_MAX);
                end
                REG_DIV: begin
                    d.div = clamp(apb_req_in.pwdata[15:0], DIV_MIN, DIV_MAX);
                end
                REG_RM_SRC: begin
                    d.rm_src_tick = apb_req_in.pwdata[RMSRC_TICK_BIT];
                    d.rm_port = apb_req_in.pwdata[RMSRC_PORT_LSB +: 2];
                end
                REG_TRIG: begin
                    d.fs_from_rm = apb_req_in.pwdata[TRIG_FS_RM_BIT];
                    d.fs_enable = apb_req_in.pwdata[TRIG_FS_EN_BIT];
                    d.route_port = apb_req_in.pwdata[TRIG_ROUTE_PORT_LSB +: 2];
                    d.route_en = apb_req_in.pwdata[TRIG_ROUTE_EN_LSB +: 4];
                end
                default: begin
                    d.hyst = q.hyst;
                end
            endcase
        end

        // read data latched in the setup cycle
        if (setup) begin
            d.rdata = apb_req_in.pwrite ? 32'h0000_0000 : rd_mux;
            d.slverr = rd_err;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
            q.phase_input_select <= PHASE_SEL_RST;
            q.quadrature_input_select <= QUAD_SEL_RST;
            q.external_clear_port_select <= XCLR_PORT_RST;
            q.position_clear_source <= CLR_SOFTWARE;
            q.hyst <= HYST_RST;
            q.mul <= FACTOR_RST;
            q.div <= FACTOR_RST;
            q.forward <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign apb_rsp_out.pready = apb_req_in.psel & apb_req_in.penable;
    assign apb_rsp_out.pslverr = apb_req_in.psel & apb_req_in.penable & q.slverr;
    assign apb_rsp_out.prdata = q.rdata;
    assign tick_out = q.tick;
    assign position_count_out = q.position_count;
    assign target_clear_out = q.clr_pulse;
    assign rate_pulse_out = rm_pulse;
    assign frame_start_enable_out = q.fs_enable;
    assign trig_event_out = q.events;
endmodule

// [verilog/qenc_pkg.sv]
package qenc_pkg;
    // ----------------------------------------
    // clock and rate multiplier timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned RM_IN_MIN_HZ = 400;
    localparam int unsigned RM_PERIOD_MAX_CYC = CLK_HZ / RM_IN_MIN_HZ;
    localparam int unsigned NUM_PORTS = 3;
    localparam int unsigned FACTOR_W = 16;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_POSITION = 8'h04;
    localparam logic [7:0] REG_CLEAR = 8'h08;
    localparam logic [7:0] REG_HYST = 8'h0c;
    localparam logic [7:0] REG_MUL = 8'h10;
    localparam logic [7:0] REG_DIV = 8'h14;
    localparam logic [7:0] REG_RM_SRC = 8'h18;
    localparam logic [7:0] REG_MUL_BOUNDS = 8'h1c;
    localparam logic [7:0] REG_DIV_BOUNDS = 8'h20;
    localparam logic [7:0] REG_TRIG = 8'h24;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int unsigned CFG_PHASE_LSB = 0;
    localparam int unsigned CFG_QUAD_LSB = 2;
    localparam int unsigned CFG_BIDIR_BIT = 4;
    localparam int unsigned CFG_XCLR_PORT_LSB = 8;
    localparam int unsigned CFG_XCLR_EDGE_BIT = 10;
    localparam int unsigned CFG_XCLR_INV_BIT = 11;
    localparam int unsigned CFG_CLR_SRC_BIT = 12;
    localparam int unsigned CLR_SW_BIT = 0;
    localparam int unsigned RMSRC_TICK_BIT = 0;
    localparam int unsigned RMSRC_PORT_LSB = 1;
    localparam int unsigned TRIG_FS_RM_BIT = 0;
    localparam int unsigned TRIG_FS_EN_BIT = 1;
    localparam int unsigned TRIG_ROUTE_PORT_LSB = 2;
    localparam int unsigned TRIG_ROUTE_EN_LSB = 4;
    localparam int unsigned BOUND_UPPER_LSB = 16;
    // ----------------------------------------
    // trigger event lanes
    // ----------------------------------------
    localparam int unsigned EV_ACQ_START = 0;
    localparam int unsigned EV_FRAME_START = 1;
    localparam int unsigned EV_LINE_START = 2;
    localparam int unsigned EV_END_EXPOSURE = 3;
    // ----------------------------------------
    // reset values and factor bounds
    // ----------------------------------------
    localparam logic [1:0] PHASE_SEL_RST = 2'h1;
    localparam logic [1:0] QUAD_SEL_RST = 2'h2;
    localparam logic [1:0] XCLR_PORT_RST = 2'h0;
    localparam logic [15:0] HYST_RST = 16'h0002;
    localparam logic [15:0] FACTOR_RST = 16'h0001;
    localparam logic [15:0] FACTOR_MIN_DEF = 16'h0001;
    localparam logic [15:0] FACTOR_MAX_DEF = 16'h0400;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic {CLR_SOFTWARE, CLR_EXTERNAL} clear_source_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;
    typedef struct packed {
        logic valid;
        logic up;
    } step_s;
endpackage

// [verilog/quad_step_decoder.sv]
module quad_step_decoder
    import qenc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic phase_in,
    input wire logic quad_in,
    output step_s step_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] prev;
        step_s step;
    } dec_s;
    dec_s q, d;

    // ----------------------------------------
    // one step per single-line change, both-line change dropped
    // ----------------------------------------
    always_comb begin
        d = q;
        d.prev = {phase_in, quad_in};
        d.step.valid = (phase_in ^ q.prev[1]) ^ (quad_in ^ q.prev[0]);
        d.step.up = ~(q.prev[1] ^ quad_in);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign step_out = q.step;
endmodule

// [verilog/rate_multiplier.sv]
module rate_multiplier
    import qenc_pkg::*;
#(
    parameter int unsigned PERIOD_MAX = RM_PERIOD_MAX_CYC,
    parameter int unsigned PERIOD_W = $clog2(PERIOD_MAX + 1)
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic source_in,
    input wire logic [FACTOR_W-1:0] mul_in,
    input wire logic [FACTOR_W-1:0] div_in,
    output logic pulse_out
);
    localparam int unsigned ACC_W = FACTOR_W + PERIOD_W + 1;
    localparam logic [PERIOD_W-1:0] CNT_LIMIT = PERIOD_W'(PERIOD_MAX);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic src_prev;
        logic seen;
        logic valid;
        logic [PERIOD_W-1:0] cnt;
        logic [PERIOD_W-1:0] period;
        logic [ACC_W-1:0] acc;
        logic pulse;
    } rm_s;
    rm_s q, d;
    logic rise;
    logic [ACC_W-1:0] limit;
    logic [ACC_W-1:0] sum;

    // ----------------------------------------
    // period measure and phase accumulator
    // ----------------------------------------
    always_comb begin
        d = q;
        rise = source_in & ~q.src_prev;
        limit = ACC_W'(div_in) * ACC_W'(q.period);
        sum = q.acc + ACC_W'(mul_in);
        d.src_prev = source_in;
        d.pulse = 1'b0;
        if (rise) begin
            d.seen = 1'b1;
            d.valid = q.seen && (q.cnt != CNT_LIMIT);
            d.period = q.cnt + PERIOD_W'(1);
            d.cnt = '0;
        end else if (q.cnt != CNT_LIMIT) begin
            d.cnt = q.cnt + PERIOD_W'(1);
        end else begin
            d.valid = 1'b0;
        end
        if (!q.valid) begin
            d.acc = '0;
        end else if (sum >= limit) begin
            d.pulse = 1'b1;
            d.acc = (sum - limit < limit) ? sum - limit : limit;
        end else begin
            d.acc = sum;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pulse_out = q.pulse;
endmodule

// [verif/encoder_model.sv]
module encoder_model
    import qenc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire step_s step_in,
    output logic phase_out,
    output logic quad_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos_q;
    // ----------------------------------------
    // shaft position, one quarter step per request
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_q <= 2'h0;
        end else if (step_in.valid) begin
            pos_q <= step_in.up ? pos_q + 2'h1 : pos_q - 2'h1;
        end
    end
    // gray code, phase leads when turning forward
    assign phase_out = ^pos_q;
    assign quad_out = pos_q[1];
endmodule

// [verif/qenc_monitor.sv]
module qenc_monitor
    import qenc_pkg::*;
#(
    parameter logic [15:0] MUL_MIN = FACTOR_MIN_DEF,
    parameter logic [15:0] MUL_MAX = FACTOR_MAX_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire apb_req_s apb_req_in,
    input wire apb_rsp_s apb_rsp_out,
    input wire logic [NUM_PORTS-1:0] port_in,
    input wire logic tick_out,
    input wire logic [31:0] position_count_out,
    input wire logic target_clear_out,
    input wire logic rate_pulse_out,
    input wire logic frame_start_enable_out,
    input wire logic [3:0] trig_event_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence seq_setup;
        apb_req_in.psel && !apb_req_in.penable;
    endsequence
    sequence seq_read(logic [7:0] ad);
        apb_req_in.psel && apb_req_in.penable && !apb_req_in.pwrite && apb_req_in.paddr == ad;
    endsequence
    a_pready_follows: assert property (
        apb_rsp_out.pready == (apb_req_in.psel && apb_req_in.penable)) else $error("pready wrong");
    a_read_position: assert property (seq_setup ##1 seq_read(REG_POSITION)
        |-> apb_rsp_out.prdata == $past(position_count_out)) else $error("position read wrong");
    a_bounds_read: assert property (seq_setup ##1 seq_read(REG_MUL_BOUNDS)
        |-> apb_rsp_out.prdata == {MUL_MAX, MUL_MIN}) else $error("bounds read wrong");
    a_unmapped_err: assert property (
        apb_req_in.psel && apb_req_in.penable && apb_req_in.paddr > REG_TRIG |-> apb_rsp_out.pslverr)
        else $error("no error on unmapped address");
    a_tick_moves: assert property (
        tick_out |-> !$stable(position_count_out)) else $error("tick without count change");
    a_step_unit: assert property (!$stable(position_count_out) |-> position_count_out == 32'h0
        || position_count_out == $past(position_count_out) + 32'h1
        || position_count_out == $past(position_count_out) - 32'h1) else $error("count jumped");
    a_clear_zero: assert property (target_clear_out
        |-> position_count_out == 32'h0 || $past(position_count_out) == 32'h0) else $error("clear pulse wrong");
    a_fs_by_write: assert property ($changed(frame_start_enable_out) |-> $past(apb_req_in.psel
        && apb_req_in.penable && apb_req_in.pwrite && apb_req_in.paddr == REG_TRIG))
        else $error("frame start enable changed alone");
    a_route_port: assert property (trig_event_out[0] || trig_event_out[2] || trig_event_out[3]
        |-> $past(port_in) != 3'h0) else $error("event without port");
endmodule

bind quad_encoder_rate_mult qenc_monitor #(.MUL_MIN(MUL_MIN), .MUL_MAX(MUL_MAX)) qenc_monitor_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .apb_req_in(apb_req_in),
    .apb_rsp_out(apb_rsp_out),
    .port_in(port_in),
    .tick_out(tick_out),
    .position_count_out(position_count_out),
    .target_clear_out(target_clear_out),
    .rate_pulse_out(rate_pulse_out),
    .frame_start_enable_out(frame_start_enable_out),
    .trig_event_out(trig_event_out)
);

// [verif/test_quad_encoder_rate_mult.sv]
module test_quad_encoder_rate_mult
    import qenc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic p0 = 1'b0;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    step_s stp = '0;
    logic a, b, tick, fse, tclr, rp, err;
    logic [31:0] pos, rd;
    logic [31:0] rs = 32'h0000004e;
    logic [3:0] trig;
    int error_cnt = 0, checks = 0, cyc = 0, seen = 0, rpc = 0, fsc = 0, n;
    int m_pos = 0, m_mark = 0, m_ticks = 0, hyst = 2;
    bit m_rev = 0, bidir = 0, hold = 0;
    bit pat [6] = '{1, 0, 0, 1, 1, 1};
    int mt [2] = '{3, 10};
    int dt [2] = '{1, 3};
    logic [7:0] ra [7] = '{REG_CONFIG, REG_HYST, REG_MUL, REG_DIV, REG_MUL_BOUNDS, REG_DIV_BOUNDS, 8'h28};
    logic [31:0] rv [7] = '{32'h9, 32'h2, 32'h1, 32'h1, 32'h04000001, 32'h04000001, 32'h0};

    quad_encoder_rate_mult #(.RM_PERIOD_MAX(200)) quad_encoder_rate_mult_inst (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .apb_req_in(req),
        .apb_rsp_out(rsp),
        .port_in({b, a, p0}),
        .tick_out(tick),
        .position_count_out(pos),
        .target_clear_out(tclr),
        .rate_pulse_out(rp),
        .frame_start_enable_out(fse),
        .trig_event_out(trig)
    );
    encoder_model encoder_model_inst (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .step_in(stp),
        .phase_out(a),
        .quad_out(b)
    );

    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (tick === 1'b1) seen <= seen + 1;
        if (rp === 1'b1) rpc <= rpc + 1;
        if (trig[EV_FRAME_START] === 1'b1) fsc <= fsc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task give_verdict();
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: wd};
        @(posedge clk_in);
        req.penable <= 1'b1;
        @(posedge clk_in);
        while (rsp.pready !== 1'b1) @(posedge clk_in);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task step(input bit up);
        int d;
        stp <= '{valid: 1'b1, up: up};
        @(posedge clk_in);
        stp.valid <= 1'b0;
        m_pos = up ? m_pos + 1 : m_pos - 1;
        d = m_rev ? m_mark - m_pos : m_pos - m_mark;
        if (hold) begin
            m_pos = 0;
            m_mark = 0;
        end else if (d > 0) begin
            m_ticks++;
            m_mark = m_pos;
        end else if (bidir && -d >= hyst) begin
            m_rev = !m_rev;
            m_ticks++;
            m_mark = m_pos;
        end
        repeat (4) @(posedge clk_in);
        chk("position", 32'(m_pos), pos);
        chk("ticks", 32'(m_ticks), 32'(seen));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            chk("register", rv[i], rd);
            chk("slverr", 32'(ra[i] == 8'h28), 32'(err));
        end
        apb(1'b1, REG_POSITION, 32'h5);
        repeat (40) step(m_pos == 0 || rnd() % 3 != 0);
        apb(1'b0, REG_POSITION, 32'h0);
        chk("position read", 32'(m_pos), rd);
        apb(1'b1, REG_CLEAR, 32'h1);
        m_pos = 0;
        m_mark = 0;
        foreach (pat[i]) step(pat[i]);
        apb(1'b1, REG_CONFIG, 32'h1409);
        p0 <= 1'b1;
        repeat (4) @(posedge clk_in);
        m_pos = 0;
        m_mark = 0;
        chk("external clear", 32'h0, pos);
        step(1'b1);
        apb(1'b1, REG_CLEAR, 32'h1);
        apb(1'b1, REG_CONFIG, 32'h1809);
        step(1'b1);
        p0 <= 1'b0;
        hold = 1;
        step(1'b1);
        hold = 0;
        apb(1'b1, REG_CONFIG, 32'h9);
        apb(1'b1, REG_TRIG, 32'h13);
        @(posedge clk_in);
        chk("frame start enable", 32'h1, 32'(fse));
        p0 <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("routed event", 32'h1, 32'(trig[EV_ACQ_START]));
        p0 <= 1'b0;
        apb(1'b1, REG_MUL, 32'h0);
        apb(1'b0, REG_MUL, 32'h0);
        chk("mul clamp", 32'(FACTOR_MIN_DEF), rd);
        apb(1'b1, REG_RM_SRC, 32'h0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, REG_MUL, 32'(mt[k]));
            apb(1'b1, REG_DIV, 32'(dt[k]));
            repeat (250) @(posedge clk_in);
            for (int j = 0; j < 27; j++) begin
                if (j == 2) n = rpc;
                p0 <= 1'b1;
                repeat (20) @(posedge clk_in);
                p0 <= 1'b0;
                repeat (20) @(posedge clk_in);
            end
            n = rpc - n - 25 * mt[k] / dt[k];
            chk("rate", 32'h1, 32'(n >= -3 && n <= 3));
        end
        apb(1'b1, REG_CLEAR, 32'h1);
        m_pos = 0;
        m_mark = 0;
        apb(1'b1, REG_HYST, 32'h3);
        hyst = 3;
        apb(1'b1, REG_CONFIG, 32'h19);
        bidir = 1;
        repeat (5) step(1'b1);
        repeat (6) step(1'b0);
        repeat (200) @(posedge clk_in);
        chk("frame start pulses", 32'(rpc), 32'(fsc));
        give_verdict();
    end
endmodule
